/* src/tamc_arm.sv */
// Trigger arming core: single and continuous arming, waiting flag
`timescale 1ns/100ps
`default_nettype none
module tamc_arm (
  input wire logic hclk,
  input wire logic hresetn,
  tamc_trig_if.arm tb
);
  logic single_reg;
  logic single_next;
  logic wtg_reg;
  logic wtg_next;
  logic accept_reg;
  wire armed_w = tb.cont | single_reg;
  // Only the selected source can complete an armed trigger
  wire fire_w = armed_w & ((tb.bus_trg & ~tb.src_ext) | (tb.ext_trg & tb.src_ext));
  // ==========================================================
  // Arming state
  always_comb begin
    single_next = single_reg;
    if (tb.rst || tb.abort) begin
      single_next = 1'b0;
    end else if (tb.single_arm) begin
      single_next = 1'b1;
    end else if (fire_w) begin
      single_next = 1'b0;
    end
  end
  // Under continuous arming an external trigger drops the flag for one cycle; a bus trigger never does
  assign wtg_next = ~tb.rst & (tb.cont | single_next) & ~(fire_w & tb.src_ext);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      single_reg <= 1'b0;
      wtg_reg <= 1'b0;
      accept_reg <= 1'b0;
    end else begin
      single_reg <= single_next;
      wtg_reg <= wtg_next;
      accept_reg <= fire_w;
    end
  end
  assign tb.accept = accept_reg;
  assign tb.waiting_for_trigger_flag = wtg_reg;
  assign tb.armed = armed_w;
  // ==========================================================
  // Checks
  a_wtg_bus_cont: assert property (@(posedge hclk) disable iff (!hresetn)
    (tb.cont && !tb.src_ext && !tb.rst) |=> tb.waiting_for_trigger_flag) else $error("wtg not held under bus continuous");
  a_wtg_ext_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    (tb.cont && tb.src_ext && tb.ext_trg && !tb.rst) |=> !tb.waiting_for_trigger_flag ##1 ($past(tb.cont && !tb.rst) -> tb.waiting_for_trigger_flag))
    else $error("wtg did not drop and return on external trigger");
  a_single_once: assert property (@(posedge hclk) disable iff (!hresetn)
    (fire_w && !tb.cont && !tb.single_arm) |=> !tb.armed) else $error("still armed after single trigger");
  a_abort_disarm: assert property (@(posedge hclk) disable iff (!hresetn)
    (tb.abort && !tb.cont) |=> (!tb.armed || tb.cont)) else $error("abort left trigger armed");
  a_rst_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    tb.rst |=> (!tb.waiting_for_trigger_flag && !single_reg)) else $error("reset command left arming state");
endmodule : tamc_arm
`default_nettype wire

/* src/tamc_pkg.sv */
// Shared constants of the trigger-arm and meter control block
package tamc_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_TRIG_VOLT = 8'h08;
  localparam logic [7:0] OFF_TRIG_CURR = 8'h0C;
  localparam logic [7:0] OFF_VOLT_SET = 8'h10;
  localparam logic [7:0] OFF_CURR_SET = 8'h14;
  localparam logic [7:0] OFF_OPER_COND = 8'h18;
  localparam logic [7:0] OFF_OPER_ENAB = 8'h1C;
  localparam logic [7:0] OFF_OPER_EVENT = 8'h20;
  localparam logic [7:0] OFF_METER_RATE = 8'h24;
  localparam logic [7:0] OFF_MEAS_VOLT = 8'h28;
  localparam logic [7:0] OFF_MEAS_CURR = 8'h2C;
  localparam logic [7:0] OFF_LIST_COUNT = 8'h30;
  localparam logic [7:0] OFF_ERROR = 8'h34;
  localparam logic [7:0] OFF_TRAN_INFO = 8'h38;
  localparam logic [7:0] OFF_LIST_SAMPLE = 8'h3C;
  localparam logic [7:0] OFF_TRAN_BASE = 8'h40;
  // ==========================================================
  // Field positions
  localparam int CTRL_CONT_BIT = 0;
  localparam int CTRL_SRC_EXT_BIT = 1;
  localparam int CMD_ARM_BIT = 0;
  localparam int CMD_TRG_BIT = 1;
  localparam int CMD_ABORT_BIT = 2;
  localparam int CMD_RST_BIT = 3;
  localparam int CMD_SAVE_INT_BIT = 4;
  localparam int CMD_SAVE_SER_BIT = 5;
  localparam int CMD_SAVE_LIM_BIT = 6;
  localparam int CMD_SAVE_OUTP_BIT = 7;
  localparam int CMD_LIST_RUN_BIT = 8;
  localparam int WTG_BIT = 5;
  // ==========================================================
  // Values
  localparam logic [7:0] RATE_50 = 8'h32;
  localparam logic [7:0] RATE_60 = 8'h3C;
  localparam logic [7:0] RATE_125 = 8'h7D;
  localparam logic [7:0] RATE_RESET = RATE_60;
  localparam logic [15:0] LIST_COUNT_ONE = 16'h0001;
  localparam logic [15:0] LIST_COUNT_RESET = 16'h0001;
  localparam logic [31:0] ERR_CMD = 32'hFFFFFF9C;
  localparam logic [31:0] ERR_NONE = 32'h00000000;
  localparam logic [31:0] SETPOINT_RESET = 32'h00000000;
  localparam int TRAN_DEPTH = 8;
endpackage : tamc_pkg

/* src/tamc_top.sv */
// AHB-Lite register file and command decoder of the trigger and meter block
//
// Local design decisions: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module tamc_top
  import tamc_pkg::*;
#(
  parameter int DATA_W = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic ext_trg,
  input wire logic [DATA_W-1:0] meas_volt,
  input wire logic [DATA_W-1:0] meas_curr,
  input wire logic tran_valid,
  input wire logic [DATA_W-1:0] tran_data,
  input wire logic list_is_current,
  input wire logic [15:0] list_sample_point,
  output logic [DATA_W-1:0] volt_setpoint,
  output logic [DATA_W-1:0] curr_setpoint,
  output logic [7:0] meter_rate,
  output logic list_start,
  output logic save_int,
  output logic save_ser,
  output logic save_lim,
  output logic save_outp
);
  // ==========================================================
  // Helpers
  function automatic logic rate_ok(input logic [7:0] r);
    rate_ok = (r == RATE_50) || (r == RATE_60) || (r == RATE_125);
  endfunction : rate_ok

  // ==========================================================
  // Bus slave: address phase capture
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic hreadyout_reg;
  logic hresp_reg;
  logic [31:0] hrdata_reg;
  wire take_w = hsel & hready & htrans[1];
  wire rd_take_w = take_w & ~hwrite;
  wire wr_take_w = take_w & hwrite;
  // Hardware never stalls: every transfer answers with zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end else begin
      wr_pend_reg <= wr_take_w;
      wr_addr_reg <= haddr;
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Write decode in data phase
  wire wr_ctrl_w = wr_pend_reg && (wr_addr_reg == OFF_CTRL);
  wire wr_cmd_w = wr_pend_reg && (wr_addr_reg == OFF_CMD);
  wire wr_tv_w = wr_pend_reg && (wr_addr_reg == OFF_TRIG_VOLT);
  wire wr_tc_w = wr_pend_reg && (wr_addr_reg == OFF_TRIG_CURR);
  wire wr_enab_w = wr_pend_reg && (wr_addr_reg == OFF_OPER_ENAB);
  wire wr_rate_w = wr_pend_reg && (wr_addr_reg == OFF_METER_RATE);
  wire wr_cnt_w = wr_pend_reg && (wr_addr_reg == OFF_LIST_COUNT);
  wire cmd_arm_w = wr_cmd_w & hwdata[CMD_ARM_BIT];
  wire cmd_trg_w = wr_cmd_w & hwdata[CMD_TRG_BIT];
  wire cmd_abort_w = wr_cmd_w & hwdata[CMD_ABORT_BIT];
  wire cmd_rst_w = wr_cmd_w & hwdata[CMD_RST_BIT];
  wire cmd_list_w = wr_cmd_w & hwdata[CMD_LIST_RUN_BIT];

  // ==========================================================
  // Control and trigger value registers
  logic cont_reg;
  logic src_ext_reg;
  logic [DATA_W-1:0] trig_volt_reg;
  logic [DATA_W-1:0] trig_curr_reg;
  logic [DATA_W-1:0] volt_set_reg;
  logic [DATA_W-1:0] curr_set_reg;
  logic [7:0] rate_reg;
  logic [15:0] list_count_reg;
  logic [15:0] oper_enab_reg;
  tamc_trig_if trig_bus ();
  assign trig_bus.cont = cont_reg;
  assign trig_bus.src_ext = src_ext_reg;
  assign trig_bus.single_arm = cmd_arm_w;
  assign trig_bus.bus_trg = cmd_trg_w;
  assign trig_bus.ext_trg = ext_trg;
  assign trig_bus.abort = cmd_abort_w;
  assign trig_bus.rst = cmd_rst_w;
  tamc_arm u_arm (
    .hclk(hclk),
    .hresetn(hresetn),
    .tb(trig_bus)
  );
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cont_reg <= 1'b0;
      src_ext_reg <= 1'b0;
    end else if (cmd_rst_w) begin
      cont_reg <= 1'b0;
    end else if (wr_ctrl_w) begin
      cont_reg <= hwdata[CTRL_CONT_BIT];
      src_ext_reg <= hwdata[CTRL_SRC_EXT_BIT];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_volt_reg <= SETPOINT_RESET;
      trig_curr_reg <= SETPOINT_RESET;
    end else begin
      if (wr_tv_w) begin
        trig_volt_reg <= hwdata[DATA_W-1:0];
      end
      if (wr_tc_w) begin
        trig_curr_reg <= hwdata[DATA_W-1:0];
      end
    end
  end
  // Setpoints only ever move on an accepted trigger
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      volt_set_reg <= SETPOINT_RESET;
      curr_set_reg <= SETPOINT_RESET;
    end else if (trig_bus.accept) begin
      volt_set_reg <= trig_volt_reg;
      curr_set_reg <= trig_curr_reg;
    end
  end
  // Illegal rates are dropped so the meter never runs an undefined window
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rate_reg <= RATE_RESET;
      list_count_reg <= LIST_COUNT_RESET;
      oper_enab_reg <= 16'h0000;
    end else begin
      if (wr_rate_w && rate_ok(hwdata[7:0]) && (hwdata[31:8] == 24'h000000)) begin
        rate_reg <= hwdata[7:0];
      end
      if (wr_cnt_w) begin
        list_count_reg <= hwdata[15:0];
      end
      if (wr_enab_w) begin
        oper_enab_reg <= hwdata[15:0];
      end
    end
  end

  // ==========================================================
  // Operation status: condition and sticky event
  logic wtg_prev_reg;
  logic [15:0] oper_event_reg;
  logic [15:0] oper_event_next;
  wire [15:0] oper_cond_w = {10'h000, trig_bus.waiting_for_trigger_flag, 5'h00};
  wire rd_event_w = rd_take_w && (haddr == OFF_OPER_EVENT);
  wire wtg_edge_w = (trig_bus.waiting_for_trigger_flag != wtg_prev_reg) & oper_enab_reg[WTG_BIT];
  always_comb begin
    oper_event_next = oper_event_reg;
    if (rd_event_w) begin
      oper_event_next = 16'h0000;
    end
    // A transition in the clearing read's cycle still lands
    if (wtg_edge_w) begin
      oper_event_next[WTG_BIT] = 1'b1;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wtg_prev_reg <= 1'b0;
      oper_event_reg <= 16'h0000;
    end else begin
      wtg_prev_reg <= trig_bus.waiting_for_trigger_flag;
      oper_event_reg <= oper_event_next;
    end
  end

  // ==========================================================
  // List run, error code and transient samples
  logic [31:0] err_reg;
  logic list_start_reg;
  logic tran_cur_reg;
  logic [3:0] tran_cnt_reg;
  logic [DATA_W-1:0] tran_mem [TRAN_DEPTH];
  wire list_ok_w = cmd_list_w && (list_count_reg == LIST_COUNT_ONE);
  wire list_bad_w = cmd_list_w && (list_count_reg != LIST_COUNT_ONE);
  wire rd_err_w = rd_take_w && (haddr == OFF_ERROR);
  wire tran_wr_w = tran_valid && (tran_cnt_reg < 4'(TRAN_DEPTH));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_reg <= ERR_NONE;
      list_start_reg <= 1'b0;
    end else begin
      list_start_reg <= list_ok_w;
      if (list_bad_w) begin
        err_reg <= ERR_CMD;
      end else if (rd_err_w) begin
        err_reg <= ERR_NONE;
      end
    end
  end
  // Samples beyond the eighth are dropped; a new list run restarts capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tran_cnt_reg <= 4'h0;
      tran_cur_reg <= 1'b0;
    end else if (list_ok_w) begin
      tran_cnt_reg <= 4'h0;
      tran_cur_reg <= list_is_current;
    end else if (tran_wr_w) begin
      tran_cnt_reg <= tran_cnt_reg + 4'h1;
    end
  end
  always_ff @(posedge hclk) begin
    if (tran_wr_w && !list_ok_w) begin
      tran_mem[tran_cnt_reg[2:0]] <= tran_data;
    end
  end

  // ==========================================================
  // Save strobes toward non-volatile storage
  logic [3:0] save_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      save_reg <= 4'h0;
    end else begin
      save_reg <= {4{wr_cmd_w}} & hwdata[CMD_SAVE_OUTP_BIT:CMD_SAVE_INT_BIT];
    end
  end

  // ==========================================================
  // Read mux, sampled in the address phase
  wire [7:0] tran_off_w = haddr - OFF_TRAN_BASE;
  wire in_tran_w = (haddr >= OFF_TRAN_BASE) && (tran_off_w[7:2] < 6'(TRAN_DEPTH)) && (haddr[1:0] == 2'b00);
  wire tran_hit_w = in_tran_w && ({1'b0, tran_off_w[4:2]} < tran_cnt_reg);
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    if (haddr == OFF_CTRL) begin
      rd_mux = {30'h00000000, src_ext_reg, cont_reg};
    end else if (haddr == OFF_TRIG_VOLT) begin
      rd_mux = 32'(trig_volt_reg);
    end else if (haddr == OFF_TRIG_CURR) begin
      rd_mux = 32'(trig_curr_reg);
    end else if (haddr == OFF_VOLT_SET) begin
      rd_mux = 32'(volt_set_reg);
    end else if (haddr == OFF_CURR_SET) begin
      rd_mux = 32'(curr_set_reg);
    end else if (haddr == OFF_OPER_COND) begin
      rd_mux = {16'h0000, oper_cond_w};
    end else if (haddr == OFF_OPER_ENAB) begin
      rd_mux = {16'h0000, oper_enab_reg};
    end else if (haddr == OFF_OPER_EVENT) begin
      rd_mux = {16'h0000, oper_event_reg};
    end else if (haddr == OFF_METER_RATE) begin
      rd_mux = {24'h000000, rate_reg};
    end else if (haddr == OFF_MEAS_VOLT) begin
      rd_mux = 32'(meas_volt);
    end else if (haddr == OFF_MEAS_CURR) begin
      rd_mux = 32'(meas_curr);
    end else if (haddr == OFF_LIST_COUNT) begin
      rd_mux = {16'h0000, list_count_reg};
    end else if (haddr == OFF_ERROR) begin
      rd_mux = err_reg;
    end else if (haddr == OFF_TRAN_INFO) begin
      rd_mux = {23'h000000, tran_cur_reg, 4'h0, tran_cnt_reg};
    end else if (haddr == OFF_LIST_SAMPLE) begin
      rd_mux = {15'h0000, list_is_current, list_sample_point};
    end else if (tran_hit_w) begin
      rd_mux = 32'(tran_mem[tran_off_w[4:2]]);
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h00000000;
    end else if (rd_take_w) begin
      hrdata_reg <= rd_mux;
    end
  end

  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;
  assign hrdata = hrdata_reg;
  assign volt_setpoint = volt_set_reg;
  assign curr_setpoint = curr_set_reg;
  assign meter_rate = rate_reg;
  assign list_start = list_start_reg;
  assign save_int = save_reg[0];
  assign save_ser = save_reg[1];
  assign save_lim = save_reg[2];
  assign save_outp = save_reg[3];

  // ==========================================================
  // Checks
  a_setpoint_load: assert property (@(posedge hclk) disable iff (!hresetn)
    trig_bus.accept |=> (volt_setpoint == $past(trig_volt_reg)) && (curr_setpoint == $past(trig_curr_reg)))
    else $error("setpoints not loaded on trigger");
  a_list_error: assert property (@(posedge hclk) disable iff (!hresetn)
    list_bad_w |=> (err_reg == ERR_CMD) && !list_start) else $error("bad loop count not flagged");
  a_rate_legal: assert property (@(posedge hclk) disable iff (!hresetn)
    rate_ok(meter_rate)) else $error("illegal meter rate held");
  a_rst_cont: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_rst_w |=> !cont_reg ##1 !trig_bus.waiting_for_trigger_flag || $past(wr_ctrl_w)) else $error("reset command kept continuous arm");
  a_event_latch: assert property (@(posedge hclk) disable iff (!hresetn)
    wtg_edge_w |=> oper_event_reg[WTG_BIT]) else $error("waiting transition not latched");
  a_tran_bound: assert property (@(posedge hclk) disable iff (!hresetn)
    tran_cnt_reg <= 4'(TRAN_DEPTH)) else $error("transient capture count past depth");
endmodule : tamc_top
`default_nettype wire

/* src/tamc_trig_if.sv */
// Carrier between register file and trigger arming core
`timescale 1ns/100ps
`default_nettype none
interface tamc_trig_if;
  logic cont;
  logic src_ext;
  logic single_arm;
  logic bus_trg;
  logic ext_trg;
  logic abort;
  logic rst;
  logic accept;
  logic waiting_for_trigger_flag;
  logic armed;
  modport regs (output cont, output src_ext, output single_arm, output bus_trg, output ext_trg,
                output abort, output rst, input accept, input waiting_for_trigger_flag, input armed);
  modport arm (input cont, input src_ext, input single_arm, input bus_trg, input ext_trg,
               input abort, input rst, output accept, output waiting_for_trigger_flag, output armed);
endinterface : tamc_trig_if
`default_nettype wire

/* tb/tamc_plant.sv */
// Output stage model: measured readings and transient samples
`timescale 1ns/100ps
`default_nettype none
module tamc_plant #(
  parameter logic [31:0] OFS = 32'h00000011,
  parameter logic [31:0] BASE = 32'h5A000000
) (
  input wire logic hclk,
  input wire logic [31:0] volt_setpoint,
  input wire logic [31:0] curr_setpoint,
  input wire logic list_start,
  input wire logic [3:0] n_samp,
  output logic [31:0] meas_volt,
  output logic [31:0] meas_curr,
  output logic tran_valid,
  output logic [31:0] tran_data
);
  logic [3:0] left = 4'h0;
  logic [31:0] idx = 32'h0;
  // ====
  // Readings
  // Readings differ from setpoints so an echo of the program is caught
  assign meas_volt = volt_setpoint + OFS;
  assign meas_curr = curr_setpoint - OFS;
  assign tran_valid = left != 4'h0;
  // Idle data is inverted so a stale capture never matches
  assign tran_data = tran_valid ? BASE + idx : ~(BASE + idx);
  always @(posedge hclk) begin
    if (list_start) begin
      left <= n_samp;
      idx <= 32'h0;
    end else if (tran_valid) begin
      left <= left - 4'h1;
      idx <= idx + 32'h1;
    end
  end
endmodule : tamc_plant
`default_nettype wire

/* tb/test_tamc_top.sv */
// Self-checking bench of the trigger-arm and meter control block
`timescale 1ns/100ps
`default_nettype none
module test_tamc_top;
  import tamc_pkg::*;
  localparam logic [31:0] OFS = 32'h00000011;
  localparam logic [31:0] BASE = 32'h5A000000;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic ext_trg = 1'b0;
  logic list_is_current = 1'b0;
  logic [15:0] list_sample_point = 16'h0;
  logic [3:0] n_samp = 4'h0;
  logic hreadyout, hresp, tran_valid, list_start, save_int, save_ser, save_lim, save_outp, cur;
  logic [31:0] hrdata, meas_volt, meas_curr, tran_data, volt_setpoint, curr_setpoint, rd, tv, tc;
  logic [7:0] meter_rate, r;
  logic [7:0] er = RATE_RESET;
  logic [15:0] pt;
  logic [3:0] pv;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  int pc [5] = '{0, 0, 0, 0, 0};
  logic [7:0] rates [3] = '{RATE_50, RATE_125, RATE_60};
  always #50 hclk = ~hclk;
  tamc_top tamc_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .ext_trg(ext_trg), .meas_volt(meas_volt), .meas_curr(meas_curr),
    .tran_valid(tran_valid), .tran_data(tran_data), .list_is_current(list_is_current),
    .list_sample_point(list_sample_point), .volt_setpoint(volt_setpoint), .curr_setpoint(curr_setpoint),
    .meter_rate(meter_rate), .list_start(list_start), .save_int(save_int), .save_ser(save_ser),
    .save_lim(save_lim), .save_outp(save_outp));
  tamc_plant #(.OFS(OFS), .BASE(BASE)) tamc_plant_inst (.hclk(hclk), .volt_setpoint(volt_setpoint),
    .curr_setpoint(curr_setpoint), .list_start(list_start), .n_samp(n_samp), .meas_volt(meas_volt),
    .meas_curr(meas_curr), .tran_valid(tran_valid), .tran_data(tran_data));
  // ====
  // Strobe counters and hang guard
  always @(posedge hclk) begin
    pv = {save_outp, save_lim, save_ser, save_int};
    for (int i = 0; i < 4; i++) if (pv[i] === 1'b1) pc[i]++;
    if (list_start === 1'b1) pc[4]++;
    cyc++;
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end
  // ====
  // Bus tasks and expectations
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : xfer
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task rchk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    check(rd, e);
    check({31'h0, hresp}, 32'h0);
  endtask : rchk
  // Strobes land one edge after the data phase; three edges cover it
  task cmd(input int b);
    wr(OFF_CMD, 32'h1 << b);
    repeat (3) @(posedge hclk);
  endtask : cmd
  task ext_pulse;
    @(posedge hclk);
    ext_trg <= 1'b1;
    @(posedge hclk);
    ext_trg <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask : ext_pulse
  function automatic logic rate_ok(input logic [7:0] v);
    return v == RATE_50 || v == RATE_60 || v == RATE_125;
  endfunction : rate_ok
  function automatic logic [31:0] samp_exp(input int k, input logic [3:0] n);
    return (k < n && k < TRAN_DEPTH) ? BASE + 32'(k) : 32'h0;
  endfunction : samp_exp
  task results;
    $display("failures %0d n_tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  // ====
  // Main sequence
  initial begin
    void'($urandom(32'h4f9198e8));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(OFF_CTRL, 32'h0);
    rchk(OFF_METER_RATE, {24'h0, RATE_RESET});
    rchk(8'h60, 32'h0);
    tv = $urandom();
    tc = $urandom();
    wr(OFF_TRIG_VOLT, tv);
    wr(OFF_TRIG_CURR, tc);
    cmd(CMD_TRG_BIT);
    check(volt_setpoint, SETPOINT_RESET);
    cmd(CMD_ARM_BIT);
    cmd(CMD_TRG_BIT);
    check(volt_setpoint, tv);
    check(curr_setpoint, tc);
    wr(OFF_TRIG_VOLT, ~tv);
    cmd(CMD_TRG_BIT);
    check(volt_setpoint, tv);
    cmd(CMD_ARM_BIT);
    cmd(CMD_ABORT_BIT);
    cmd(CMD_TRG_BIT);
    check(volt_setpoint, tv);
    wr(OFF_CTRL, 32'h2);
    cmd(CMD_ARM_BIT);
    cmd(CMD_TRG_BIT);
    check(volt_setpoint, tv);
    ext_pulse();
    check(volt_setpoint, ~tv);
    wr(OFF_CTRL, 32'h1);
    rchk(OFF_CTRL, 32'h1);
    for (int i = 0; i < 3; i++) begin
      tv = $urandom();
      wr(OFF_TRIG_VOLT, tv);
      cmd(CMD_ABORT_BIT);
      cmd(CMD_TRG_BIT);
      check(volt_setpoint, tv);
      rchk(OFF_OPER_COND, 32'h20);
    end
    wr(OFF_OPER_ENAB, 32'h20);
    wr(OFF_CTRL, 32'h3);
    xfer(1'b0, OFF_OPER_EVENT, 32'h0);
    tv = $urandom();
    wr(OFF_TRIG_VOLT, tv);
    ext_pulse();
    check(volt_setpoint, tv);
    rchk(OFF_OPER_COND, 32'h20);
    rchk(OFF_OPER_EVENT, 32'h20);
    rchk(OFF_OPER_EVENT, 32'h0);
    wr(OFF_OPER_ENAB, 32'h0);
    ext_pulse();
    rchk(OFF_OPER_EVENT, 32'h0);
    cmd(CMD_RST_BIT);
    xfer(1'b0, OFF_CTRL, 32'h0);
    check(rd & 32'h1, 32'h0);
    rchk(OFF_OPER_COND, 32'h0);
    wr(OFF_TRIG_VOLT, ~tv);
    ext_pulse();
    check(volt_setpoint, tv);
    for (int i = 0; i < 8; i++) begin
      r = (i < 3) ? rates[i] : 8'($urandom());
      if (rate_ok(r)) er = r;
      wr(OFF_METER_RATE, {24'h0, r});
      rchk(OFF_METER_RATE, {24'h0, er});
      check({24'h0, meter_rate}, {24'h0, er});
    end
    for (int b = 0; b < 4; b++) begin
      cmd(CMD_SAVE_INT_BIT + b);
      for (int j = 0; j < 5; j++) check(32'(pc[j]), 32'(j <= b && j < 4));
    end
    wr(OFF_LIST_COUNT, 32'h2);
    cmd(CMD_LIST_RUN_BIT);
    check(32'(pc[4]), 32'h0);
    rchk(OFF_ERROR, ERR_CMD);
    rchk(OFF_ERROR, ERR_NONE);
    wr(OFF_LIST_COUNT, {16'h0, LIST_COUNT_ONE});
    for (int i = 0; i < 2; i++) begin
      cur = 1'($urandom());
      pt = 16'($urandom());
      list_is_current <= cur;
      list_sample_point <= pt;
      n_samp <= (i == 0) ? 4'h3 : 4'hA;
      cmd(CMD_LIST_RUN_BIT);
      repeat (12) @(posedge hclk);
      rchk(OFF_TRAN_INFO, {23'h0, cur, 4'h0, (i == 0) ? 4'h3 : 4'h8});
      for (int k = 0; k < 8; k++) rchk(OFF_TRAN_BASE + 8'(4 * k), samp_exp(k, n_samp));
      rchk(OFF_LIST_SAMPLE, {15'h0, cur, pt});
      check(32'(pc[4]), 32'(i + 1));
    end
    rchk(OFF_MEAS_VOLT, tv + OFS);
    rchk(OFF_MEAS_CURR, tc - OFS);
    // Mid-run reset must bring control and rate back to their power-up values
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    rchk(OFF_CTRL, 32'h0);
    rchk(OFF_METER_RATE, {24'h0, RATE_RESET});
    results();
  end
endmodule : test_tamc_top
`default_nettype wire
